// [fsc_defines.vh]
/*
 Constants for the front-side bus sideband control block: states, soft init
 length, native error bit, reset vector width and reset timing. Assumes a single 100 MHz bus clock.
*/
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH
`define FSC_CLK_PERIOD_NS 10
`define FSC_RESET_RELEASE_CLKS 2
`define FSC_ST_RUN 2'h0
`define FSC_ST_INIT 2'h1
`define FSC_ST_HALT 2'h2
`define FSC_INIT_CLKS 4'h4
`define FSC_NATIVE_ERR_BIT 5
`define FSC_RESET_VECTOR_W 32
`endif

// [fsc_sideband.v]
/*
 Sideband control and status logic of a bus processor: snoop stall, internal
 error, numeric error ignore, soft initialisation, local interrupt fallback and
 bus lock. Assumes all inputs arrive on or can be sampled by the bus clock clk;
 asynchronous inputs are synchronised here. Bus outputs are active low.
*/
`timescale 1ns/1ps
`include "fsc_defines.vh"

// How it works
// R1: Snoop stall drives hit and hit-modified together.
// R2: Internal error output held until reset.
// R3: Internal error issues one halt transaction.
// R4: Ignore input active masks pending FP error.
// R5: Ignore inactive: pending error raises FP exception.
// R6: Native error bit set disables ignore input.
// R7: System holds ignore valid at target ready.
// R8: Soft init resets integer state, keeps caches.
// R9: Soft init restarts at configured reset vector.
// R10: Snooping continues during soft init.
// R11: Soft init input accepted asynchronously.
// R12: Controller off: lines become maskable and NMI.
// R13: Interrupt controller enabled out of reset.
// R14: Bus lock held across whole atomic sequence.
// R15: Priority agent waits for lock release.
// R16: Bus outputs released within two clocks of reset.
// R17: Asynchronous inputs pass two-flop synchronisers.
module fsc_sideband (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Snoop
  input wire snoop_req,
  input wire snoop_hit,
  input wire snoop_hit_modified,
  input wire snoop_stall_req,
  output reg snoop_hit_n,
  output reg snoop_hit_modified_n,
  // Error
  input wire internal_fault,
  output reg internal_error_n,
  output reg halt_transaction,
  // Numeric error
  input wire numeric_error_ignore_n,
  input wire [31:0] control_register_zero,
  input wire fp_error_pending,
  input wire fp_noncontrol_issue,
  output reg fp_exception,
  // Soft init
  input wire soft_init_n,
  input wire [`FSC_RESET_VECTOR_W-1:0] reset_vector,
  output reg integer_regs_reset,
  output reg fetch_restart,
  output reg [`FSC_RESET_VECTOR_W-1:0] fetch_addr,
  output reg snoop_active,
  // Local interrupts
  input wire [1:0] local_irq_lines,
  input wire lic_disable,
  output reg [1:0] lic_irq,
  output reg maskable_irq,
  output reg nmi_irq,
  // Bus lock
  input wire atomic_first_start,
  input wire atomic_last_end,
  output reg bus_lock_n
);

  reg [1:0] rst_sync_reg;
  wire rst_n;
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  wire [3:0] async_in;
  wire ign_n_s;
  wire init_n_s;
  wire [1:0] lirq_s;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] init_cnt_reg;
  reg lic_en_reg;
  reg lock_reg;
  reg fault_seen_reg;
  reg [`FSC_RESET_VECTOR_W-1:0] vec_reg;
  reg vec_cap_reg;
  wire ignore_ok;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign async_in = {local_irq_lines, soft_init_n, numeric_error_ignore_n};

  // Each asynchronous input gets its own two-flop synchroniser.
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_sync
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          // Each stage rests at its pin's idle level, so no false edge follows reset.
          sync1_reg[i] <= (i < 2) ? 1'b1 : 1'b0;
          sync2_reg[i] <= (i < 2) ? 1'b1 : 1'b0;
        end else begin
          sync1_reg[i] <= async_in[i]; // R17 R11
          sync2_reg[i] <= sync1_reg[i]; // R17
        end
      end
    end
  endgenerate
  assign ign_n_s = sync2_reg[0];
  assign init_n_s = sync2_reg[1];
  assign lirq_s = sync2_reg[3:2];

  // The ignore input only counts while the native error bit is clear.
  assign ignore_ok = !ign_n_s && !control_register_zero[`FSC_NATIVE_ERR_BIT]; // R6

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `FSC_ST_RUN: begin
        if (!init_n_s) begin
          state_next = `FSC_ST_INIT;
        end
      end
      `FSC_ST_INIT: begin
        if (init_n_s && init_cnt_reg == `FSC_INIT_CLKS) begin
          state_next = `FSC_ST_RUN;
        end
      end
      `FSC_ST_HALT: begin
        state_next = `FSC_ST_HALT;
      end
      default: begin
        state_next = `FSC_ST_RUN;
      end
    endcase
    if (internal_fault) begin
      state_next = `FSC_ST_HALT;
    end
  end

  // The reset vector is captured once, on the first clock after reset release.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_cap_reg <= 1'b0;
      vec_reg <= {`FSC_RESET_VECTOR_W{1'b0}};
    end else if (!vec_cap_reg) begin
      vec_cap_reg <= 1'b1;
      vec_reg <= reset_vector; // R9
    end
  end

  // Outputs other than snoop_active are deasserted at once on reset, well inside two clocks.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `FSC_ST_RUN;
      init_cnt_reg <= 4'h0;
      lic_en_reg <= 1'b1; // R13
      lock_reg <= 1'b0;
      fault_seen_reg <= 1'b0;
      snoop_hit_n <= 1'b1; // R16
      snoop_hit_modified_n <= 1'b1;
      internal_error_n <= 1'b1;
      halt_transaction <= 1'b0;
      fp_exception <= 1'b0;
      integer_regs_reset <= 1'b0;
      fetch_restart <= 1'b0;
      fetch_addr <= {`FSC_RESET_VECTOR_W{1'b0}};
      snoop_active <= 1'b1;
      lic_irq <= 2'h0;
      maskable_irq <= 1'b0;
      nmi_irq <= 1'b0;
      bus_lock_n <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (state_reg == `FSC_ST_INIT) begin
        if (init_cnt_reg != `FSC_INIT_CLKS) begin
          init_cnt_reg <= init_cnt_reg + 4'h1;
        end
      end else begin
        init_cnt_reg <= 4'h0;
      end
      // A stall drives both lines together; each new stall request re-drives.
      if (snoop_req && snoop_stall_req) begin
        snoop_hit_n <= 1'b0; // R1
        snoop_hit_modified_n <= 1'b0; // R1
      end else begin
        snoop_hit_n <= !(snoop_req && snoop_hit);
        snoop_hit_modified_n <= !(snoop_req && snoop_hit_modified);
      end
      snoop_active <= 1'b1; // R10
      // The error output is sticky until reset.
      if (internal_fault) begin
        internal_error_n <= 1'b0; // R2
        fault_seen_reg <= 1'b1;
      end
      halt_transaction <= internal_fault && !fault_seen_reg; // R3
      fp_exception <= fp_noncontrol_issue && fp_error_pending && !ignore_ok; // R4 R5
      integer_regs_reset <= (state_next == `FSC_ST_INIT) && (state_reg != `FSC_ST_INIT); // R8
      fetch_restart <= (state_reg == `FSC_ST_INIT) && (state_next == `FSC_ST_RUN); // R9
      if ((state_reg == `FSC_ST_INIT) && (state_next == `FSC_ST_RUN)) begin
        fetch_addr <= vec_reg; // R9
      end
      lic_en_reg <= !lic_disable;
      if (lic_en_reg) begin
        lic_irq <= lirq_s;
        maskable_irq <= 1'b0;
        nmi_irq <= 1'b0;
      end else begin
        lic_irq <= 2'h0;
        maskable_irq <= lirq_s[0]; // R12
        nmi_irq <= lirq_s[1]; // R12
      end
      // Lock spans first start to last end; priority agents wait on it.
      if (atomic_first_start) begin
        lock_reg <= 1'b1;
        bus_lock_n <= 1'b0; // R14
      end else if (atomic_last_end) begin
        lock_reg <= 1'b0;
        bus_lock_n <= 1'b1; // R14
      end else begin
        bus_lock_n <= !lock_reg;
      end
    end
  end

endmodule

// [fsc_system_model.sv]
/* System logic model: priority agent and ignore driver. Shares the bus clock. */
`timescale 1ns/1ps
module fsc_system_model (
  // Clock
  input wire clk,
  // Priority agent
  input wire bus_lock_n,
  input wire priority_want,
  output reg priority_bus_request_n = 1'h1,
  output reg priority_owns = 1'h0,
  // Ignore input
  input wire ignore_want,
  input wire target_ready_n,
  output reg numeric_error_ignore_n = 1'h1
);
  always @(posedge clk) begin
    priority_bus_request_n <= !priority_want;
    priority_owns <= priority_want && !priority_bus_request_n && bus_lock_n;
    if (!target_ready_n) numeric_error_ignore_n <= !ignore_want;
  end
endmodule

// [fsc_checker.sv]
/* Port assertions for fsc_sideband. Bound to each instance of it. */
`timescale 1ns/1ps
module fsc_checker (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Watched ports
  input wire snoop_req,
  input wire snoop_stall_req,
  input wire snoop_hit_n,
  input wire snoop_hit_modified_n,
  input wire internal_fault,
  input wire internal_error_n,
  input wire halt_transaction,
  input wire snoop_active,
  input wire atomic_first_start,
  input wire atomic_last_end,
  input wire bus_lock_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_quiet;
    !halt_transaction [*8];
  endsequence
  a_stall_pair: assert property (snoop_req && snoop_stall_req |=>
    !snoop_hit_n && !snoop_hit_modified_n) else $error("stall");
  a_error_set: assert property (internal_fault |-> ##[1:3] !internal_error_n)
    else $error("internal_error_n set");
  a_error_hold: assert property (!internal_error_n |=> !internal_error_n)
    else $error("internal_error_n hold");
  a_halt_once: assert property (halt_transaction |=> s_quiet)
    else $error("halt");
  a_lock_hold: assert property (!bus_lock_n && !atomic_last_end |=> !bus_lock_n)
    else $error("lock hold");
  a_lock_end: assert property (atomic_last_end && !atomic_first_start |=> bus_lock_n)
    else $error("lock end");
  a_reset_quiet: assert property (disable iff (1'h0) !resetn ##1 !resetn |->
    bus_lock_n && internal_error_n && snoop_hit_n) else $error("reset");
  a_snoop_live: assert property (snoop_active)
    else $error("snoop");
endmodule
bind fsc_sideband fsc_checker u_chk (.*);

// [test_fsc_sideband.sv]
/* Bench for fsc_sideband. Needs the system model and checker files. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module test_fsc_sideband;
  reg clk = 0, resetn = 0, snoop_req = 0, snoop_hit = 0, snoop_hit_modified = 0;
  reg snoop_stall_req = 0, internal_fault = 0, fp_error_pending = 0, fp_noncontrol_issue = 0;
  reg soft_init_n = 1, lic_disable = 0, atomic_first_start = 0, atomic_last_end = 0;
  reg priority_want = 0, ignore_want = 0, target_ready_n = 1;
  reg [1:0] local_irq_lines = 0;
  reg [31:0] control_register_zero = 0, reset_vector = 0;
  wire numeric_error_ignore_n, priority_bus_request_n, priority_owns, snoop_hit_n, fp_exception;
  wire snoop_hit_modified_n, internal_error_n, halt_transaction, integer_regs_reset;
  wire fetch_restart, snoop_active, maskable_irq, nmi_irq, bus_lock_n;
  wire [31:0] fetch_addr;
  wire [1:0] lic_irq;
  integer mismatches = 0, n_tests = 0, seed = 32'hbcce9ca3, i, k, seen;
  fsc_sideband u_dut (.*);
  fsc_system_model u_sys (.*);
  initial forever #5 clk = ~clk;
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task print_verdict;
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    reset_vector <= $random(seed);
    tick(10);
    resetn <= 1'h1;
    tick(6);
    for (i = 0; i < 4; i++) begin
      ignore_want <= i[1];
      target_ready_n <= 1'h0;
      tick(1);
      target_ready_n <= 1'h1;
      tick(6);
      k = $random(seed);
      control_register_zero <= {k[31:6], i[0], k[4:0]};
      fp_error_pending <= 1'h1;
      fp_noncontrol_issue <= 1'h1;
      tick(1);
      fp_noncontrol_issue <= 1'h0;
      #1 `CHK("fp", !(i[1] && !i[0]), fp_exception)
      tick(1);
    end
    for (i = 0; i < 5; i++) begin
      lic_disable <= i < 4;
      local_irq_lines <= i ^ (i >> 2);
      tick(4);
      #1 `CHK("irq", i[3:0], {lic_irq & {2{i == 4}}, nmi_irq, maskable_irq})
      tick(1);
    end
    atomic_first_start <= 1'h1;
    priority_want <= 1'h1;
    tick(1);
    atomic_first_start <= 1'h0;
    repeat (3 + k[2:0]) begin
      tick(1);
      #1 `CHK("lock", 2'h0, {bus_lock_n, priority_owns})
    end
    tick(1);
    atomic_last_end <= 1'h1;
    tick(1);
    atomic_last_end <= 1'h0;
    #1 `CHK("unlock", 1'h1, bus_lock_n)
    tick(1);
    priority_want <= 1'h0;
    #1 `CHK("owner", 1'h1, priority_owns)
    tick(1);
    soft_init_n <= 1'h0;
    snoop_req <= 1'h1;
    snoop_stall_req <= 1'h1;
    seen = 0;
    for (i = 0; i < 60 && fetch_restart !== 1'h1; i++) begin
      tick(1);
      if (i == 6) begin
        soft_init_n <= 1'h1;
        snoop_stall_req <= 1'h0;
      end
      #1 seen = seen | integer_regs_reset;
    end
    `CHK("restart", 1'h1, fetch_restart)
    `CHK("init", 1, seen)
    `CHK("vector", reset_vector, fetch_addr)
    tick(1);
    internal_fault <= 1'h1;
    snoop_hit <= 1'h1;
    seen = 0;
    repeat (6) begin
      tick(1);
      internal_fault <= 1'h0;
      #1 seen = seen + halt_transaction;
    end
    `CHK("halt", 1, seen)
    `CHK("hit", 2'h1, {snoop_hit_n, snoop_hit_modified_n})
    `CHK("internal_error_n", 1'h0, internal_error_n)
    tick(1);
    resetn <= 1'h0;
    tick(2);
    #1 `CHK("release", 2'h3, {internal_error_n, bus_lock_n})
    tick(1);
    resetn <= 1'h1;
    tick(6);
    #1 `CHK("internal_error_n clear", 1'h1, internal_error_n)
    print_verdict;
  end
endmodule
